// ===== verilog/tcc_core.sv
// transmit per-channel controller: registers, indirect bytes, pcm path
// assumes bus and pcm stream are synchronous to clock_i
`timescale 1ns/10ps
// Summary of operation
// - indirect mode bit resets to zero; software must set it to one.
// - per-channel enable applies control and idle bytes to pcm data and forwards signalling bytes to the transmitter.
// - busy stays high during an access, falls on a high-speed clock tick.
// - each indirect access completes within 640 ns.
// - writing a valid address with direction while busy is low starts one internal access; the write is ignored while busy.
// - direction bit 7 one means read, zero means write.
// - data buffer holds write byte, or read result after completion.
// - for a read, data buffer holds the byte within 640 ns.
// - addresses 01h-18h are pcm control bytes of channels 1-24.
// - addresses 19h-30h are idle code bytes of channels 1-24.
// - addresses 31h-48h are signalling control bytes of channels 1-24.
// - pcm control bits: invert 7, idle 6, milliwatt 5, msb flip 4, suppress 1:0.
// - full inversion inverts the whole channel byte.
// - msb flip alone inverts msb; with inversion inverts all but msb.
// - milliwatt beats idle, idle beats inversions, in every format.
// - suppress codes: none, jam bit 8 or 7, dds byte, jam bit 7.
module tcc_core
    import tcc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic pcm_valid_i,
    output logic pcm_ready_o,
    input wire logic [7:0] backplane_tx_pcm_i,
    input wire logic [4:0] pcm_chan_i,
    input wire logic sig_frame_i,
    input wire logic sig_bit_i,
    input wire logic [7:0] milliwatt_byte_i,
    output logic basic_transmitter_valid_o,
    input wire logic basic_transmitter_ready_i,
    output logic [7:0] basic_transmitter_data_o,
    output logic [7:0] basic_transmitter_sig_ctrl_o,
    output logic per_channel_enable_o,
    output logic indirect_mode_select_o
);
    // ==========================================
    // functions
    function automatic logic [6:0] tcc_index(input logic [6:0] ia);
        tcc_index = ia - TCC_IA_PCM_FIRST;
    endfunction : tcc_index

    function automatic logic tcc_valid_ia(input logic [6:0] ia);
        tcc_valid_ia = (ia >= TCC_IA_PCM_FIRST) && (ia <= TCC_IA_LAST);
    endfunction : tcc_valid_ia

    // ==========================================
    // registers
    logic [1:0] config_ff;
    logic [7:0] addr_ctrl_ff;
    logic [7:0] data_buf_ff;
    logic busy_ff;
    logic [7:0] rdata_ff;
    logic [7:0] bytes_ff [TCC_NUM_BYTES];
    tcc_state_t state_ff;
    tcc_state_t nxt_state;
    logic [1:0] hs_div_ff;
    logic hs_tick;
    logic [2:0] tick_cnt_ff;
    logic start_acc;
    logic [6:0] cur_ia;
    logic [6:0] cur_idx;

    assign cur_ia = addr_ctrl_ff[6:0];
    assign cur_idx = tcc_index(cur_ia);
    assign hs_tick = (hs_div_ff == 2'(TCC_HS_DIV - 1));
    assign start_acc = reg_wr_i && (reg_addr_i == TCC_OFS_ADDR_CTRL) && !busy_ff;

    // ==========================================
    // high-speed clock enable
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hs_div_ff <= 2'h0;
        else
            hs_div_ff <= hs_div_ff + 2'h1;
    end

    // ==========================================
    // configuration register
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            config_ff <= TCC_CONFIG_RST;
        else if (reg_wr_i && reg_addr_i == TCC_OFS_CONFIG)
            config_ff <= reg_wdata_i[1:0];
    end

    // ==========================================
    // address/control register
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            addr_ctrl_ff <= TCC_ADDR_CTRL_RST;
        else if (start_acc)
            addr_ctrl_ff <= reg_wdata_i;
    end

    // ==========================================
    // access sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            TCC_ST_IDLE:
                if (start_acc)
                    nxt_state = TCC_ST_WAIT;
            TCC_ST_WAIT:
                if (hs_tick && tick_cnt_ff == 3'(TCC_ACCESS_TICKS - 1))
                    nxt_state = TCC_ST_DONE;
            TCC_ST_DONE:
                nxt_state = TCC_ST_IDLE;
            default:
                nxt_state = TCC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_ff <= TCC_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tick_cnt_ff <= 3'h0;
        else if (state_ff != TCC_ST_WAIT)
            tick_cnt_ff <= 3'h0;
        else if (hs_tick)
            tick_cnt_ff <= tick_cnt_ff + 3'h1;
    end

    // busy falls after completion, aligned to a tick
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            busy_ff <= 1'b0;
        else if (start_acc)
            busy_ff <= 1'b1;
        else if (hs_tick && state_ff == TCC_ST_IDLE)
            busy_ff <= 1'b0;
    end

    // ==========================================
    // data buffer
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            data_buf_ff <= TCC_DATA_BUF_RST;
        else if (state_ff == TCC_ST_DONE && addr_ctrl_ff[TCC_AC_DIR_BIT])
        begin
            if (tcc_valid_ia(cur_ia))
                data_buf_ff <= bytes_ff[cur_idx];
            else
                data_buf_ff <= TCC_UNDEF_READ;
        end
        else if (reg_wr_i && reg_addr_i == TCC_OFS_DATA_BUF)
            data_buf_ff <= reg_wdata_i;
    end

    // ==========================================
    // per-channel byte store
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < TCC_NUM_BYTES; i++)
                bytes_ff[i] <= TCC_BYTE_RST;
        end
        else if (state_ff == TCC_ST_DONE && !addr_ctrl_ff[TCC_AC_DIR_BIT] && tcc_valid_ia(cur_ia))
        begin
            if (cur_ia < TCC_IA_IDLE_FIRST)
                bytes_ff[cur_idx] <= data_buf_ff & TCC_PCM_USED_MASK;
            else
                bytes_ff[cur_idx] <= data_buf_ff;
        end
    end

    // ==========================================
    // register read port
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_ff <= 8'h00;
        else if (reg_rd_i)
        begin
            if (reg_addr_i == TCC_OFS_CONFIG)
                rdata_ff <= {6'h00, config_ff};
            else if (reg_addr_i == TCC_OFS_STATUS)
                rdata_ff <= {busy_ff, 7'h00};
            else if (reg_addr_i == TCC_OFS_ADDR_CTRL)
                rdata_ff <= addr_ctrl_ff;
            else if (reg_addr_i == TCC_OFS_DATA_BUF)
                rdata_ff <= data_buf_ff;
            else
                rdata_ff <= 8'h00;
        end
    end

    // ==========================================
    // pcm data path
    logic [7:0] pcm_ctl;
    logic [7:0] idle_byte;
    logic [7:0] sig_byte;
    logic [7:0] pcm_out;
    logic [1:0] zsel;
    logic [4:0] ch;

    assign ch = (pcm_chan_i < 5'(TCC_NUM_CHAN)) ? pcm_chan_i : 5'h0;
    assign pcm_ctl = bytes_ff[ch];
    assign idle_byte = bytes_ff[7'(ch) + 7'(TCC_NUM_CHAN)];
    assign sig_byte = bytes_ff[7'(ch) + 7'(2 * TCC_NUM_CHAN)];
    assign zsel = {pcm_ctl[TCC_PCM_ZSH_BIT], pcm_ctl[TCC_PCM_ZSL_BIT]};

    always_comb
    begin
        pcm_out = backplane_tx_pcm_i;
        if (config_ff[TCC_CFG_PER_CHANNEL_ENABLE_BIT])
        begin
            if (pcm_ctl[TCC_PCM_MW_BIT])
                pcm_out = milliwatt_byte_i;
            else if (pcm_ctl[TCC_PCM_IDLE_BIT])
                pcm_out = idle_byte;
            else
            begin
                if (pcm_ctl[TCC_PCM_INV_BIT])
                    pcm_out = ~pcm_out;
                if (pcm_ctl[TCC_PCM_MSB_BIT])
                    pcm_out[7] = ~pcm_out[7];
            end
            if (pcm_out == 8'h00)
            begin
                case (zsel)
                    TCC_ZCS_JAM8:
                        if (sig_frame_i && !sig_bit_i)
                            pcm_out = 8'h02;
                        else
                            pcm_out = 8'h01;
                    TCC_ZCS_DDS:
                        pcm_out = TCC_DDS_BYTE;
                    TCC_ZCS_JAM7:
                        pcm_out = 8'h02;
                    default:
                        pcm_out = 8'h00;
                endcase
            end
        end
    end

    // ==========================================
    // two-entry output buffer: output register plus one skid slot
    logic [7:0] skid_data_ff;
    logic [7:0] skid_sig_ff;
    logic skid_full_ff;
    logic [7:0] in_sig;
    logic push;
    logic out_free;

    assign in_sig = config_ff[TCC_CFG_PER_CHANNEL_ENABLE_BIT] ? sig_byte : 8'h00;
    assign push = pcm_valid_i && !skid_full_ff;
    assign out_free = !basic_transmitter_valid_o || basic_transmitter_ready_i;

    // skid slot keeps a byte while the receiver stalls
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            skid_full_ff <= 1'b0;
            skid_data_ff <= 8'h00;
            skid_sig_ff <= 8'h00;
        end
        else if (out_free)
            skid_full_ff <= 1'b0;
        else if (push)
        begin
            skid_full_ff <= 1'b1;
            skid_data_ff <= pcm_out;
            skid_sig_ff <= in_sig;
        end
    end

    // ==========================================
    // output register, reloaded when empty or when the receiver takes a byte
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            basic_transmitter_valid_o <= 1'b0;
            basic_transmitter_data_o <= 8'h00;
            basic_transmitter_sig_ctrl_o <= 8'h00;
        end
        else if (out_free)
        begin
            if (skid_full_ff)
            begin
                basic_transmitter_valid_o <= 1'b1;
                basic_transmitter_data_o <= skid_data_ff;
                basic_transmitter_sig_ctrl_o <= skid_sig_ff;
            end
            else
            begin
                basic_transmitter_valid_o <= push;
                basic_transmitter_data_o <= pcm_out;
                basic_transmitter_sig_ctrl_o <= in_sig;
            end
        end
    end

    // ==========================================
    // registered status outputs
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pcm_ready_o <= 1'b0;
            per_channel_enable_o <= 1'b0;
            indirect_mode_select_o <= 1'b0;
        end
        else
        begin
            pcm_ready_o <= out_free || !(skid_full_ff || push);
            per_channel_enable_o <= config_ff[TCC_CFG_PER_CHANNEL_ENABLE_BIT];
            indirect_mode_select_o <= config_ff[TCC_CFG_IND_BIT];
        end
    end

    assign reg_rdata_o = rdata_ff;
endmodule : tcc_core

// ===== verilog/tcc_pkg.sv
// constants for the transmit per-channel controller
// assumes a single 50 MHz clock domain
package tcc_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] TCC_OFS_CONFIG = 8'h30;
    localparam logic [7:0] TCC_OFS_STATUS = 8'h31;
    localparam logic [7:0] TCC_OFS_ADDR_CTRL = 8'h32;
    localparam logic [7:0] TCC_OFS_DATA_BUF = 8'h33;
    // ==========================================
    // field positions
    localparam int TCC_CFG_PER_CHANNEL_ENABLE_BIT = 0;
    localparam int TCC_CFG_IND_BIT = 1;
    localparam int TCC_STAT_BUSY_BIT = 7;
    localparam int TCC_AC_DIR_BIT = 7;
    localparam int TCC_PCM_INV_BIT = 7;
    localparam int TCC_PCM_IDLE_BIT = 6;
    localparam int TCC_PCM_MW_BIT = 5;
    localparam int TCC_PCM_MSB_BIT = 4;
    localparam int TCC_PCM_ZSL_BIT = 1;
    localparam int TCC_PCM_ZSH_BIT = 0;
    localparam logic [7:0] TCC_PCM_USED_MASK = 8'hf3;
    // ==========================================
    // reset values
    localparam logic [1:0] TCC_CONFIG_RST = 2'h0;
    localparam logic [7:0] TCC_ADDR_CTRL_RST = 8'h00;
    localparam logic [7:0] TCC_DATA_BUF_RST = 8'h00;
    localparam logic [7:0] TCC_BYTE_RST = 8'h00;
    // ==========================================
    // internal address map
    localparam logic [6:0] TCC_IA_PCM_FIRST = 7'h01;
    localparam logic [6:0] TCC_IA_IDLE_FIRST = 7'h19;
    localparam logic [6:0] TCC_IA_SIG_FIRST = 7'h31;
    localparam logic [6:0] TCC_IA_LAST = 7'h48;
    localparam int TCC_NUM_BYTES = 72;
    localparam int TCC_NUM_CHAN = 24;
    localparam logic [7:0] TCC_UNDEF_READ = 8'hff;
    // ==========================================
    // pcm patterns
    localparam logic [7:0] TCC_DDS_BYTE = 8'h98;
    localparam logic [1:0] TCC_ZCS_NONE = 2'h0;
    localparam logic [1:0] TCC_ZCS_JAM8 = 2'h1;
    localparam logic [1:0] TCC_ZCS_DDS = 2'h2;
    localparam logic [1:0] TCC_ZCS_JAM7 = 2'h3;
    // ==========================================
    // timing
    localparam int TCC_CLK_PERIOD_NS = 20;
    localparam int TCC_ACCESS_MAX_NS = 640;
    localparam int TCC_ACCESS_CYC = TCC_ACCESS_MAX_NS / TCC_CLK_PERIOD_NS;
    localparam int TCC_HS_DIV = 4;
    localparam int TCC_ACCESS_TICKS = TCC_ACCESS_CYC / TCC_HS_DIV - 1;
    // ==========================================
    // access states
    typedef enum logic [1:0] {
        TCC_ST_IDLE = 2'b00,
        TCC_ST_WAIT = 2'b01,
        TCC_ST_DONE = 2'b11
    } tcc_state_t;
endpackage : tcc_pkg

// ===== bench/tcc_core_props.sv
// port assertions for the transmit per-channel controller
// assumes one clock domain, bound onto tcc_core
`timescale 1ns/10ps
module tcc_core_props
    import tcc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic pcm_valid_i,
    input wire logic pcm_ready_o,
    input wire logic basic_transmitter_valid_o,
    input wire logic basic_transmitter_ready_i,
    input wire logic [7:0] basic_transmitter_data_o,
    input wire logic [7:0] basic_transmitter_sig_ctrl_o,
    input wire logic per_channel_enable_o,
    input wire logic indirect_mode_select_o
);
    // ==========
    // helpers
    logic [5:0] since_ac_ff;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    always_ff @(posedge clock_i or negedge rst_b_i)
        if (!rst_b_i)
            since_ac_ff <= 6'h3f;
        else if (reg_wr_i && reg_addr_i == TCC_OFS_ADDR_CTRL)
            since_ac_ff <= 6'h00;
        else if (since_ac_ff != 6'h3f)
            since_ac_ff <= since_ac_ff + 6'h01;
    sequence s_start;
        reg_wr_i && reg_addr_i == TCC_OFS_ADDR_CTRL && reg_wdata_i[6:0] inside {[7'h01:7'h48]};
    endsequence
    sequence s_stat;
        reg_rd_i && reg_addr_i == TCC_OFS_STATUS;
    endsequence
    sequence s_cfg;
        reg_wr_i && reg_addr_i == TCC_OFS_CONFIG;
    endsequence
    // ==========
    // properties
    a_busy_rises: assert property (s_start ##2 s_stat |=> reg_rdata_o[7])
        else $error("busy low during access");
    a_busy_bounded: assert property (since_ac_ff == 6'h23 ##0 s_stat |=> !reg_rdata_o[7])
        else $error("access too long");
    a_per_channel_enable_on: assert property (s_cfg ##0 reg_wdata_i[0] |-> ##[1:2] per_channel_enable_o)
        else $error("enable not set");
    a_per_channel_enable_off: assert property (s_cfg ##0 !reg_wdata_i[0] |-> ##[1:2] !per_channel_enable_o)
        else $error("enable not cleared");
    a_ind_on: assert property (s_cfg ##0 reg_wdata_i[1] |-> ##[1:2] indirect_mode_select_o)
        else $error("indirect mode not set");
    a_push_out: assert property (pcm_valid_i && pcm_ready_o |-> ##[1:2] basic_transmitter_valid_o)
        else $error("byte not forwarded");
    a_stall_hold: assert property (basic_transmitter_valid_o && !basic_transmitter_ready_i |=>
        basic_transmitter_valid_o && $stable(basic_transmitter_data_o))
        else $error("output changed in stall");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_sig_off: assert property ($rose(basic_transmitter_valid_o) && !per_channel_enable_o
        && !$past(per_channel_enable_o, 3) |-> basic_transmitter_sig_ctrl_o == 8'h00)
        else $error("signalling byte while disabled");
endmodule : tcc_core_props
bind tcc_core tcc_core_props i_tcc_core_props (.*);

// ===== bench/tcc_tx_sink.sv
// stand-in for the basic transmitter taking processed bytes
// assumes ready is sampled on the rising clock edge
`timescale 1ns/10ps
module tcc_tx_sink
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [1:0] mode_i,
    output logic ready_o
);
    // ==========
    // mode 0 prompt, 1 slow, 2 stopped
    always_ff @(posedge clock_i or negedge rst_b_i)
        if (!rst_b_i)
            ready_o <= 1'b0;
        else
            ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && $urandom_range(0, 2) == 0);
endmodule : tcc_tx_sink

// ===== bench/tb_tcc_core.sv
// self-checking bench for the transmit per-channel controller
// assumes tcc_core, tcc_tx_sink and the bound checker
`timescale 1ns/10ps
module tb_tcc_core
    import tcc_pkg::*;
;
    logic clock_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic pcm_valid_i = 1'b0, sig_frame_i = 1'b0, sig_bit_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, backplane_tx_pcm_i = 8'h00, milliwatt_byte_i = 8'h00;
    logic [4:0] pcm_chan_i = 5'h00;
    logic [1:0] sink_mode = 2'h0;
    logic [7:0] reg_rdata_o, basic_transmitter_data_o, basic_transmitter_sig_ctrl_o;
    logic pcm_ready_o, basic_transmitter_valid_o, basic_transmitter_ready_i;
    logic per_channel_enable_o, indirect_mode_select_o;
    logic [7:0] mem [1:72];
    logic [15:0] expq [$];
    int n_errors = 0, checked = 0, cyc = 0, pushes = 0, pops = 0;
    tcc_core i_tcc_core (.*);
    tcc_tx_sink i_tcc_tx_sink (.clock_i, .rst_b_i, .mode_i(sink_mode), .ready_o(basic_transmitter_ready_i));
    initial
        forever #10 clock_i = ~clock_i;
    // ==========
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(posedge clock_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic acc(input logic [7:0] ac, input logic [7:0] d, output logic [7:0] q);
        int n;
        logic [7:0] s;
        if (!ac[7])
            wr(TCC_OFS_DATA_BUF, d);
        wr(TCC_OFS_ADDR_CTRL, ac);
        n = 0;
        s = 8'h80;
        while (s[7] !== 1'b0 && n < 30)
        begin
            rd(TCC_OFS_STATUS, s);
            n++;
        end
        chk({15'h0000, n <= 18}, 16'h0001);
        rd(TCC_OFS_DATA_BUF, q);
    endtask : acc
    function automatic logic [7:0] pcm_exp(input logic [7:0] c, i, b, m, input logic f, s);
        logic [7:0] r;
        r = b ^ {c[7] ^ c[4], {7{c[7]}}};
        if (c[6])
            r = i;
        if (c[5])
            r = m;
        if (r == 8'h00)
            case ({c[0], c[1]})
                2'h1: r = (f && !s) ? 8'h02 : 8'h01;
                2'h2: r = TCC_DDS_BYTE;
                2'h3: r = 8'h02;
                default: r = 8'h00;
            endcase
        return r;
    endfunction : pcm_exp
    task automatic push(input logic en);
        int ch;
        logic [7:0] b, m;
        logic [1:0] fs;
        ch = $urandom_range(0, 23);
        b = $urandom_range(0, 1) ? 8'($urandom) : {8{1'($urandom)}};
        m = 8'($urandom);
        fs = 2'($urandom);
        while (pcm_ready_o !== 1'b1 || pushes - pops > 1)
            @(posedge clock_i);
        pcm_valid_i <= 1'b1;
        backplane_tx_pcm_i <= b;
        pcm_chan_i <= 5'(ch);
        milliwatt_byte_i <= m;
        {sig_frame_i, sig_bit_i} <= fs;
        expq.push_back(en ? {pcm_exp(mem[ch + 1], mem[ch + 25], b, m, fs[1], fs[0]), mem[ch + 49]}
            : {b, 8'h00});
        pushes++;
        @(posedge clock_i);
        pcm_valid_i <= 1'b0;
        @(posedge clock_i);
    endtask : push
    task automatic drain();
        while (pops != pushes)
            @(posedge clock_i);
    endtask : drain
    always @(posedge clock_i)
    begin
        if (basic_transmitter_valid_o === 1'b1 && basic_transmitter_ready_i === 1'b1)
        begin
            chk({basic_transmitter_data_o, basic_transmitter_sig_ctrl_o},
                expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
            pops++;
        end
        cyc++;
        if (cyc > 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // ==========
    // tests
    initial
    begin
        logic [7:0] q, d;
        logic [7:0] msk [5] = '{8'h03, 8'h80, 8'hff, 8'hff, 8'hff};
        logic [6:0] bad [3] = '{7'h00, 7'h49, 7'h7f};
        q = $urandom(78058);
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        for (int a = 0; a < 5; a++)
        begin
            rd(8'h30 + 8'(a), q);
            chk(q & msk[a], 8'h00);
        end
        wr(TCC_OFS_CONFIG, 8'h03);
        repeat (2) @(posedge clock_i);
        chk({indirect_mode_select_o, per_channel_enable_o}, 2'h3);
        $display("reset and config test done");
        for (int i = 1; i <= 72; i++)
        begin
            d = 8'($urandom) & (i <= 24 ? 8'hf3 : i > 48 ? 8'hcf : 8'hff);
            mem[i] = d;
            acc({1'b0, 7'(i)}, d, q);
        end
        foreach (bad[k])
            acc({1'b0, bad[k]}, 8'h3c, q);
        acc(8'h80, 8'h00, q);
        chk(q, TCC_UNDEF_READ);
        for (int i = 1; i <= 72; i++)
        begin
            acc({1'b1, 7'(i)}, 8'h00, q);
            chk(q, mem[i]);
        end
        acc({1'b0, 7'h01}, 8'hff, q);
        acc({1'b1, 7'h01}, 8'h00, q);
        chk(q, 8'hf3);
        mem[1] = 8'hf3;
        $display("indirect access test done");
        wr(TCC_OFS_DATA_BUF, 8'hb3);
        wr(TCC_OFS_ADDR_CTRL, 8'h05);
        repeat (2) @(posedge clock_i);
        wr(TCC_OFS_ADDR_CTRL, 8'h86);
        rd(TCC_OFS_STATUS, q);
        chk(q[7], 1'b1);
        repeat (32) @(posedge clock_i);
        rd(TCC_OFS_STATUS, q);
        chk(q[7], 1'b0);
        rd(TCC_OFS_ADDR_CTRL, q);
        chk(q, 8'h05);
        mem[5] = 8'hb3;
        acc(8'h85, 8'h00, q);
        chk(q, 8'hb3);
        $display("busy test done");
        for (int k = 0; k < 200; k++)
        begin
            sink_mode <= k < 100 ? 2'h0 : 2'h1;
            push(1'b1);
        end
        drain();
        sink_mode <= 2'h2;
        push(1'b1);
        push(1'b1);
        repeat (3) @(posedge clock_i);
        chk({pcm_ready_o, basic_transmitter_valid_o}, 2'h1);
        sink_mode <= 2'h1;
        drain();
        wr(TCC_OFS_CONFIG, 8'h02);
        repeat (2) @(posedge clock_i);
        for (int k = 0; k < 40; k++)
            push(1'b0);
        drain();
        $display("stream test done");
        give_verdict();
    end
endmodule : tb_tcc_core
